/* File: src/mcpm_clock_power.v */
`timescale 1ns/1ps
`include "mcpm_consts.vh"

// Contract
// - machine cycle spans four internal clocks
// - economy divides internal rate by 4/64/1024
// - idle stops cpu, peripherals keep clocking
// - power-down stops every internal clock
// - timer count every 4 or 12 clocks
// - power-down bit enters power-down state
// - idle bit enters idle state
module mcpm_clock_power (
    input wire i_ref_clk,
    input wire i_reset,
    input wire [`MCPM_ADDR_W-1:0] i_avs_address,
    input wire i_avs_read,
    input wire i_avs_write,
    input wire [31:0] i_avs_writedata,
    input wire [3:0] i_avs_byteenable,
    input wire i_wake_irq,
    output reg [31:0] o_avs_readdata,
    output reg o_avs_waitrequest,
    output reg [1:0] o_avs_response,
    output reg o_cpu_clk_en,
    output reg o_periph_clk_en,
    output reg o_mcyc_strobe,
    output reg o_tcnt_strobe,
    output reg o_idle,
    output reg o_power_down
);
    localparam ST_RUN = 3'b001;
    localparam ST_IDLE = 3'b010;
    localparam ST_PD = 3'b100;

    reg [2:0] state;
    reg idle_request;
    reg power_down_request;
    reg [1:0] gen_flag;
    reg econ_en;
    reg [1:0] econ_sel;
    reg tcnt_slow;
    reg [10:0] econ_cnt;
    reg econ_tick;
    reg answered;
    reg [2:0] next_state;
    reg [10:0] econ_ratio;
    reg [31:0] next_readdata;
    reg [1:0] next_response;
    wire mcyc_raw;
    wire tcnt_raw;

    wire req = (i_avs_read | i_avs_write) & ~answered;
    // a write lands on the edge that sees waitrequest low, not before
    wire wr_en = i_avs_write & answered & i_avs_byteenable[0];
    wire sel_ctrl = (i_avs_address == `MCPM_OFF_CTRL);
    wire sel_econ = (i_avs_address == `MCPM_OFF_ECON);
    wire sel_status = (i_avs_address == `MCPM_OFF_STATUS);
    wire any_wake = i_wake_irq;
    wire clocks_on = (state != ST_PD);
    wire leaving = (state != ST_RUN) && (next_state == ST_RUN);

    always @* begin
        case (econ_sel)
            `MCPM_ECON_SEL_DIV64: econ_ratio = `MCPM_ECON_DIV64;
            `MCPM_ECON_SEL_DIV1024: econ_ratio = `MCPM_ECON_DIV1024;
            default: econ_ratio = `MCPM_ECON_DIV4;
        endcase
    end

    // economy prescaler feeding every internal rate
    always @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            econ_cnt <= `MCPM_ZERO11;
            econ_tick <= 1'b0;
        end else if (!clocks_on) begin
            econ_tick <= 1'b0;
        end else if (!econ_en) begin
            econ_cnt <= `MCPM_ZERO11;
            econ_tick <= 1'b1;
        end else if (econ_cnt >= econ_ratio - `MCPM_ONE11) begin
            econ_cnt <= `MCPM_ZERO11;
            econ_tick <= 1'b1;
        end else begin
            econ_cnt <= econ_cnt + `MCPM_ONE11;
            econ_tick <= 1'b0;
        end
    end

    mcpm_pulse_div #(.W(4)) u_mcyc (
        .i_ref_clk(i_ref_clk),
        .i_reset(i_reset),
        .i_run(state == ST_RUN),
        .i_tick(econ_tick),
        .i_ratio(`MCPM_CLK_PER_MCYC),
        .o_strobe(mcyc_raw)
    );

    mcpm_pulse_div #(.W(4)) u_tcnt (
        .i_ref_clk(i_ref_clk),
        .i_reset(i_reset),
        .i_run(clocks_on),
        .i_tick(econ_tick),
        .i_ratio(tcnt_slow ? `MCPM_CLK_PER_TCNT_SLOW : `MCPM_CLK_PER_TCNT_FAST),
        .o_strobe(tcnt_raw)
    );

    // requests act from run; idle may still step on to power-down
    always @* begin
        next_state = state;
        case (state)
            ST_RUN: begin
                if (power_down_request)
                    next_state = ST_PD;
                else if (idle_request)
                    next_state = ST_IDLE;
            end
            ST_IDLE: begin
                if (any_wake)
                    next_state = ST_RUN;
                else if (power_down_request)
                    next_state = ST_PD;
            end
            ST_PD: begin
                if (any_wake)
                    next_state = ST_RUN;
            end
            default: next_state = ST_RUN;
        endcase
    end

    always @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            state <= ST_RUN;
        end else begin
            state <= next_state;
        end
    end

    // a wake exit clears both requests and wins over a write in the same cycle
    always @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            idle_request <= 1'b0;
            power_down_request <= 1'b0;
            gen_flag <= 2'h0;
        end else if (leaving) begin
            idle_request <= 1'b0;
            power_down_request <= 1'b0;
        end else if (wr_en && sel_ctrl) begin
            idle_request <= i_avs_writedata[`MCPM_CTRL_IDLE_BIT];
            power_down_request <= i_avs_writedata[`MCPM_CTRL_PD_BIT];
            gen_flag <= {i_avs_writedata[`MCPM_CTRL_GF1_BIT],
                         i_avs_writedata[`MCPM_CTRL_GF0_BIT]};
        end
    end

    always @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            econ_en <= 1'b0;
            econ_sel <= `MCPM_ECON_SEL_DIV4;
            tcnt_slow <= 1'b0;
        end else if (wr_en && sel_econ) begin
            econ_en <= i_avs_writedata[`MCPM_ECON_EN_BIT];
            econ_sel <= i_avs_writedata[`MCPM_ECON_SEL_MSB:`MCPM_ECON_SEL_LSB];
            tcnt_slow <= i_avs_writedata[`MCPM_ECON_T12_BIT];
        end
    end

    // status is read only, so a write to it is refused like an unmapped one
    always @* begin
        next_readdata = `MCPM_ZERO32;
        next_response = `MCPM_RESP_OKAY;
        if (sel_ctrl) begin
            next_readdata = {28'h0000000, gen_flag, power_down_request, idle_request};
        end else if (sel_econ) begin
            next_readdata = {28'h0000000, tcnt_slow, econ_sel, econ_en};
        end else if (sel_status && !i_avs_write) begin
            next_readdata = {29'h00000000, state};
        end else begin
            next_response = `MCPM_RESP_SLVERR;
        end
    end

    // avalon slave: one wait cycle, answer stands for the second edge
    always @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            answered <= 1'b0;
            o_avs_waitrequest <= 1'b1;
            o_avs_readdata <= `MCPM_ZERO32;
            o_avs_response <= `MCPM_RESP_OKAY;
        end else begin
            answered <= req;
            o_avs_waitrequest <= ~req;
            o_avs_readdata <= `MCPM_ZERO32;
            o_avs_response <= `MCPM_RESP_OKAY;
            if (req) begin
                o_avs_response <= next_response;
                if (i_avs_read)
                    o_avs_readdata <= next_readdata;
            end
        end
    end

    always @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            o_cpu_clk_en <= 1'b0;
            o_periph_clk_en <= 1'b0;
            o_mcyc_strobe <= 1'b0;
            o_tcnt_strobe <= 1'b0;
            o_idle <= 1'b0;
            o_power_down <= 1'b0;
        end else begin
            o_cpu_clk_en <= (next_state == ST_RUN);
            o_periph_clk_en <= (next_state != ST_PD);
            // gated by the next state so a strobe in flight never outlasts the state
            o_mcyc_strobe <= mcyc_raw & (next_state == ST_RUN);
            o_tcnt_strobe <= tcnt_raw & (next_state != ST_PD);
            o_idle <= (next_state == ST_IDLE);
            o_power_down <= (next_state == ST_PD);
        end
    end
endmodule

/* File: src/mcpm_consts.vh */
`ifndef MCPM_CONSTS_VH
`define MCPM_CONSTS_VH

// register word offsets (byte addresses on a 32-bit avalon word bus)
`define MCPM_ADDR_W 4
`define MCPM_OFF_CTRL 4'h0
`define MCPM_OFF_ECON 4'h4
`define MCPM_OFF_STATUS 4'h8
`define MCPM_OFF_WAKE 4'hc

// control register fields
`define MCPM_CTRL_IDLE_BIT 0
`define MCPM_CTRL_PD_BIT 1
`define MCPM_CTRL_GF0_BIT 2
`define MCPM_CTRL_GF1_BIT 3

// economy register fields
`define MCPM_ECON_EN_BIT 0
`define MCPM_ECON_SEL_LSB 1
`define MCPM_ECON_SEL_MSB 2
`define MCPM_ECON_T12_BIT 3
`define MCPM_ECON_SEL_DIV4 2'h0
`define MCPM_ECON_SEL_DIV64 2'h1
`define MCPM_ECON_SEL_DIV1024 2'h2

// divider figures
`define MCPM_CLK_PER_MCYC 4'h4
`define MCPM_CLK_PER_TCNT_FAST 4'h4
`define MCPM_CLK_PER_TCNT_SLOW 4'hc
`define MCPM_ECON_DIV4 11'h004
`define MCPM_ECON_DIV64 11'h040
`define MCPM_ECON_DIV1024 11'h400
`define MCPM_ONE4 4'h1
`define MCPM_ONE11 11'h001
`define MCPM_ZERO32 32'h00000000
`define MCPM_ZERO11 11'h000

// avalon response codes
`define MCPM_RESP_OKAY 2'h0
`define MCPM_RESP_SLVERR 2'h2

`endif

/* File: src/mcpm_pulse_div.v */
`timescale 1ns/1ps
`include "mcpm_consts.vh"

// emits one strobe every i_ratio enabled input strobes
module mcpm_pulse_div #(
    parameter W = 4
) (
    input wire i_ref_clk,
    input wire i_reset,
    input wire i_run,
    input wire i_tick,
    input wire [W-1:0] i_ratio,
    output reg o_strobe
);
    reg [W-1:0] count;
    wire last = (count >= i_ratio - {{(W-1){1'b0}}, 1'b1});

    always @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
            count <= {W{1'b0}};
            o_strobe <= 1'b0;
        end else if (!i_run) begin
            o_strobe <= 1'b0;
        end else if (i_tick) begin
            o_strobe <= last;
            count <= last ? {W{1'b0}} : count + {{(W-1){1'b0}}, 1'b1};
        end else begin
            o_strobe <= 1'b0;
        end
    end
endmodule

/* File: tb/mcpm_checker.sv */
`timescale 1ns/1ps
`include "mcpm_consts.vh"
module mcpm_checker (
    input logic i_ref_clk,
    input logic i_reset,
    input logic [`MCPM_ADDR_W-1:0] i_avs_address,
    input logic i_avs_read,
    input logic i_avs_write,
    input logic [31:0] i_avs_writedata,
    input logic [3:0] i_avs_byteenable,
    input logic i_wake_irq,
    input logic [31:0] o_avs_readdata,
    input logic o_avs_waitrequest,
    input logic [1:0] o_avs_response,
    input logic o_cpu_clk_en,
    input logic o_periph_clk_en,
    input logic o_mcyc_strobe,
    input logic o_tcnt_strobe,
    input logic o_idle,
    input logic o_power_down
);
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (i_reset);
    wire req = i_avs_read | i_avs_write;
    wire wctl = i_avs_write && o_avs_waitrequest && i_avs_address == `MCPM_OFF_CTRL
        && i_avs_byteenable[0] && !i_wake_irq;
    cpu_run_only_a: assert property (o_cpu_clk_en |-> !o_idle && !o_power_down)
        else $error("cpu clock on outside run");
    idle_periph_a: assert property (o_idle |-> o_periph_clk_en && !o_cpu_clk_en && !o_mcyc_strobe)
        else $error("idle clock enables wrong");
    pd_all_off_a: assert property (o_power_down |-> !o_periph_clk_en && !o_tcnt_strobe)
        else $error("clock running in power-down");
    mcyc_gap_a: assert property (o_mcyc_strobe |=> !o_mcyc_strobe [*3])
        else $error("machine cycle shorter than four");
    tcnt_gap_a: assert property (o_tcnt_strobe |=> !o_tcnt_strobe [*3])
        else $error("timer count faster than four");
    bus_answer_a: assert property (req && o_avs_waitrequest |=> !o_avs_waitrequest)
        else $error("bus answer late");
    idle_enter_a: assert property (
        wctl && i_avs_writedata[1:0] == 2'b01 && !o_power_down |-> ##[1:3] o_idle)
        else $error("idle not entered");
    pd_enter_a: assert property (wctl && i_avs_writedata[1] |-> ##[1:3] o_power_down)
        else $error("power-down not entered");
    wake_exit_a: assert property ((o_idle || o_power_down) && i_wake_irq |-> ##[1:4] o_cpu_clk_en)
        else $error("wake did not resume run");
    cover property (o_idle);
    cover property (o_power_down);
    cover property (req && !o_avs_waitrequest && o_avs_response == 2'b10);
endmodule
bind mcpm_clock_power mcpm_checker chk (.*);

/* File: tb/tb_mcpm_clock_power.sv */
`timescale 1ns/1ps
`include "mcpm_consts.vh"
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin error_cnt++; \
    $display("FAIL %0t %h %h", $time, a, e); end end
module tb_mcpm_clock_power;
    logic i_ref_clk = 0, i_reset = 1, i_avs_read = 0, i_avs_write = 0, i_wake_irq = 0;
    logic [3:0] i_avs_address = 0, i_avs_byteenable = 0;
    logic [31:0] i_avs_writedata = 0, o_avs_readdata, rd;
    logic [1:0] o_avs_response, rsp;
    logic o_avs_waitrequest, o_cpu_clk_en, o_periph_clk_en, o_mcyc_strobe, o_tcnt_strobe;
    logic o_idle, o_power_down;
    int error_cnt = 0, checks = 0, n;
    mcpm_clock_power dut (.*);
    always #2 i_ref_clk = ~i_ref_clk;
    task bus(input logic w, input logic [3:0] a, input logic [31:0] d, input logic [3:0] be);
        i_avs_write <= w;
        i_avs_read <= !w;
        i_avs_address <= a;
        i_avs_writedata <= d;
        i_avs_byteenable <= be;
        @(posedge i_ref_clk);
        while (o_avs_waitrequest !== 1'b0) @(posedge i_ref_clk);
        rd = o_avs_readdata;
        rsp = o_avs_response;
        i_avs_write <= 0;
        i_avs_read <= 0;
        @(posedge i_ref_clk);
    endtask
    // clocks between two strobes, measured twice so a restart does not count
    task ckper(input logic t, input int e);
        repeat (2) begin
            n = 0;
            do @(posedge i_ref_clk); while ((t ? o_tcnt_strobe : o_mcyc_strobe) !== 1'b1);
            do begin
                @(posedge i_ref_clk);
                n++;
            end while ((t ? o_tcnt_strobe : o_mcyc_strobe) !== 1'b1);
        end
        `CHK(n, e)
    endtask
    task wake;
        i_wake_irq <= 1;
        @(posedge i_ref_clk);
        i_wake_irq <= 0;
        repeat (4) @(posedge i_ref_clk);
    endtask
    task complete_run;
        $display("errors %0d checks %0d", error_cnt, checks);
        if (error_cnt == 0 && checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        #240000;
        error_cnt++;
        complete_run;
    end
    initial begin
        repeat (6) @(posedge i_ref_clk);
        i_reset <= 0;
        @(posedge i_ref_clk);
        bus(0, `MCPM_OFF_STATUS, 0, 4'hf);
        `CHK(rd, 32'h1)
        ckper(0, 4);
        ckper(1, 4);
        bus(1, `MCPM_OFF_ECON, 32'h8, 4'hf);
        ckper(1, 12);
        for (int s = 0; s < 3; s++) begin
            bus(1, `MCPM_OFF_ECON, {29'h0, s[1:0], 1'b1}, 4'hf);
            ckper(0, 16 << (4 * s));
        end
        bus(1, `MCPM_OFF_ECON, 32'h0, 4'hf);
        bus(1, `MCPM_OFF_CTRL, 32'h1, 4'h0);
        bus(0, `MCPM_OFF_STATUS, 0, 4'hf);
        `CHK(rd, 32'h1)
        bus(1, `MCPM_OFF_CTRL, 32'h1, 4'hf);
        bus(0, `MCPM_OFF_STATUS, 0, 4'hf);
        `CHK(rd, 32'h2)
        `CHK({o_cpu_clk_en, o_periph_clk_en}, 2'b01)
        ckper(1, 4);
        wake;
        bus(0, `MCPM_OFF_CTRL, 0, 4'hf);
        `CHK(rd, 32'h0)
        bus(1, `MCPM_OFF_CTRL, 32'he, 4'hf);
        bus(0, `MCPM_OFF_STATUS, 0, 4'hf);
        `CHK(rd, 32'h4)
        `CHK({o_cpu_clk_en, o_periph_clk_en}, 2'b00)
        wake;
        bus(0, `MCPM_OFF_CTRL, 0, 4'hf);
        `CHK(rd, 32'hc)
        bus(1, `MCPM_OFF_CTRL, 32'h1, 4'hf);
        i_reset <= 1;
        repeat (2) @(posedge i_ref_clk);
        i_reset <= 0;
        @(posedge i_ref_clk);
        bus(0, `MCPM_OFF_STATUS, 0, 4'hf);
        `CHK(rd, 32'h1)
        bus(0, `MCPM_OFF_CTRL, 0, 4'hf);
        `CHK(rd, 32'h0)
        bus(1, `MCPM_OFF_CTRL, 32'h1, 4'hf);
        bus(1, `MCPM_OFF_CTRL, 32'h2, 4'hf);
        bus(0, `MCPM_OFF_STATUS, 0, 4'hf);
        `CHK(rd, 32'h4)
        wake;
        bus(0, `MCPM_OFF_WAKE, 0, 4'hf);
        `CHK({rsp, rd}, 34'h200000000)
        complete_run;
    end
endmodule
